// >>> rtl/dhr_chan.v
// One converter channel: holding value and output code registers.
// Assumes loads and trigger are one-cycle pulses on clk_sys_in.
`timescale 1ns/10ps
module dhr_chan #(
    parameter W = 12
) (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire ld_full_in,
    input wire [W-1:0] full_in,
    input wire ld_hi_in,
    input wire [7:0] hi_in,
    input wire trig_en_in,
    input wire trig_in,
    output reg [W-1:0] hold_out,
    output reg [W-1:0] code_out
);
    // Holding value update; full load wins over byte load
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hold_out <= {W{1'b0}};
        end else if (ld_full_in) begin
            hold_out <= full_in;
        end else if (ld_hi_in) begin
            hold_out[W-1:W-8] <= hi_in;
        end
    end

    // Output code: follows holding one clock late, or on trigger
    // With the trigger enabled, a load in the trigger cycle waits
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            code_out <= {W{1'b0}};
        end else if (!trig_en_in || trig_in) begin
            code_out <= hold_out;
        end
    end
endmodule

// >>> rtl/dhr_map.vh
// Constants for the DAC data holding register front end.
// Assumes includers use word indexes from the APB address bits 7:2.
// Summary of operation
// - Right high nibble feeds holding bits 11:8
// - Right low byte feeds holding bits 7:0
// - Right low write commits full 12-bit value
// - Left high byte feeds holding bits 11:4
// - Left low bits 7:4 feed bits 3:0
// - Left low write commits full 12-bit value
// - Byte register feeds holding bits 11:4
// - Byte write keeps holding low nibble unchanged
// - Right high and output high upper bits zero
// - Dual right low write loads both channels
// - Dual left low write loads both channels
// - Dual byte write loads both upper bytes
// - Dual left low bits 7:4 are LSBs
// - Output high is read-only top nibble
// - Output low is read-only bottom byte
// - Second channel and dual registers are optional
// - Output follows holding one clock later, or trigger
// - Dual load moves both outputs together when neither trigger is enabled
`ifndef DHR_MAP_VH
`define DHR_MAP_VH

// Register indexes; byte address is four times the index
`define DHR_IDX_CH1_RH 6'h08
`define DHR_IDX_CH1_RL 6'h09
`define DHR_IDX_CH1_LH 6'h0c
`define DHR_IDX_CH1_LL 6'h0d
`define DHR_IDX_CH1_B 6'h10
`define DHR_IDX_CH2_RH 6'h14
`define DHR_IDX_CH2_RL 6'h15
`define DHR_IDX_CH2_LH 6'h18
`define DHR_IDX_CH2_LL 6'h19
`define DHR_IDX_CH2_B 6'h1c
`define DHR_IDX_D1_RH 6'h20
`define DHR_IDX_D1_RL 6'h21
`define DHR_IDX_D2_RH 6'h22
`define DHR_IDX_D2_RL 6'h23
`define DHR_IDX_D1_LH 6'h24
`define DHR_IDX_D1_LL 6'h25
`define DHR_IDX_D2_LH 6'h26
`define DHR_IDX_D2_LL 6'h27
`define DHR_IDX_D1_B 6'h28
`define DHR_IDX_D2_B 6'h29
`define DHR_IDX_CH1_OH 6'h2c
`define DHR_IDX_CH1_OL 6'h2d
`define DHR_IDX_CH2_OH 6'h30
`define DHR_IDX_CH2_OL 6'h31
`define DHR_IDX_CTRL 6'h34
`define DHR_IDX_SWTRIG 6'h35

// Field positions
`define DHR_BIT_TEN1 0
`define DHR_BIT_TEN2 1
`define DHR_BIT_SW1 0
`define DHR_BIT_SW2 1

// Reset values
`define DHR_RST_BYTE 8'h00
`define DHR_RST_NIB 4'h0
`define DHR_RST_CTRL 2'h0
`define DHR_RST_CODE 12'h000

`endif

// >>> rtl/dhr_regs.v
// Top of the DAC data holding register front end, APB slave.
// Assumes an APB3 master on clk_sys_in and asynchronous trigger pins.
`timescale 1ns/10ps
`include "dhr_map.vh"
module dhr_regs #(
    parameter HAS_CH2 = 1 // Second channel and dual registers built
) (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire trig_ch1_in,
    input wire trig_ch2_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    output wire [11:0] ch1_code_out,
    output wire [11:0] ch2_code_out
);
    // Word index of the access
    wire [5:0] idx;
    // Access phase of an APB transfer
    wire acc;
    // Write committed at the edge where pready is sampled
    wire wr;
    // Low byte of write data
    wire [7:0] wd;
    // Address is a real register in this build
    reg mapped;
    // Read value for the addressed register
    reg [7:0] rd_val;

    // Channel 1 staged single registers
    reg [3:0] c1_rh_r;
    reg [7:0] c1_rl_r;
    reg [7:0] c1_lh_r;
    reg [3:0] c1_ll_r;
    reg [7:0] c1_b_r;
    // Channel 2 staged single registers
    reg [3:0] c2_rh_r;
    reg [7:0] c2_rl_r;
    reg [7:0] c2_lh_r;
    reg [3:0] c2_ll_r;
    reg [7:0] c2_b_r;
    // Dual-mode registers, one set per channel
    reg [3:0] d1_rh_r;
    reg [7:0] d1_rl_r;
    reg [3:0] d2_rh_r;
    reg [7:0] d2_rl_r;
    reg [7:0] d1_lh_r;
    reg [3:0] d1_ll_r;
    reg [7:0] d2_lh_r;
    reg [3:0] d2_ll_r;
    reg [7:0] d1_b_r;
    reg [7:0] d2_b_r;
    // Trigger enable bits, one per channel
    reg [1:0] trigger_enable_r;
    // Software trigger pulses, self clearing
    reg [1:0] swtrig_r;

    // Load requests toward the channels
    reg ld1_full;
    reg [11:0] full1;
    reg ld1_hi;
    reg [7:0] hi1;
    reg ld2_full;
    reg [11:0] full2;
    reg ld2_hi;
    reg [7:0] hi2;

    // Synchronised trigger pin edges
    wire pin1_rise;
    wire pin2_rise;
    // Channel holding values, visible for debug only
    wire [11:0] hold1;
    wire [11:0] hold2;

    assign idx = paddr_in[7:2];
    assign acc = psel_in & penable_in;
    assign wd = pwdata_in[7:0];
    assign wr = acc & pready_out & pwrite_in & mapped;

    // Address decode; second channel space only when built
    always @* begin
        case (idx)
            `DHR_IDX_CH1_RH, `DHR_IDX_CH1_RL,
            `DHR_IDX_CH1_LH, `DHR_IDX_CH1_LL,
            `DHR_IDX_CH1_B, `DHR_IDX_CH1_OH,
            `DHR_IDX_CH1_OL, `DHR_IDX_CTRL,
            `DHR_IDX_SWTRIG: begin
                mapped = 1'b1;
            end
            `DHR_IDX_CH2_RH, `DHR_IDX_CH2_RL,
            `DHR_IDX_CH2_LH, `DHR_IDX_CH2_LL,
            `DHR_IDX_CH2_B, `DHR_IDX_CH2_OH,
            `DHR_IDX_CH2_OL,
            `DHR_IDX_D1_RH, `DHR_IDX_D1_RL,
            `DHR_IDX_D2_RH, `DHR_IDX_D2_RL,
            `DHR_IDX_D1_LH, `DHR_IDX_D1_LL,
            `DHR_IDX_D2_LH, `DHR_IDX_D2_LL,
            `DHR_IDX_D1_B, `DHR_IDX_D2_B: begin
                mapped = (HAS_CH2 != 0);
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Read mux; reserved bits read as zero
    always @* begin
        case (idx)
            `DHR_IDX_CH1_RH: begin
                rd_val = {4'h0, c1_rh_r};
            end
            `DHR_IDX_CH1_RL: begin
                rd_val = c1_rl_r;
            end
            `DHR_IDX_CH1_LH: begin
                rd_val = c1_lh_r;
            end
            `DHR_IDX_CH1_LL: begin
                rd_val = {c1_ll_r, 4'h0};
            end
            `DHR_IDX_CH1_B: begin
                rd_val = c1_b_r;
            end
            `DHR_IDX_CH2_RH: begin
                rd_val = {4'h0, c2_rh_r};
            end
            `DHR_IDX_CH2_RL: begin
                rd_val = c2_rl_r;
            end
            `DHR_IDX_CH2_LH: begin
                rd_val = c2_lh_r;
            end
            `DHR_IDX_CH2_LL: begin
                rd_val = {c2_ll_r, 4'h0};
            end
            `DHR_IDX_CH2_B: begin
                rd_val = c2_b_r;
            end
            `DHR_IDX_D1_RH: begin
                rd_val = {4'h0, d1_rh_r};
            end
            `DHR_IDX_D1_RL: begin
                rd_val = d1_rl_r;
            end
            `DHR_IDX_D2_RH: begin
                rd_val = {4'h0, d2_rh_r};
            end
            `DHR_IDX_D2_RL: begin
                rd_val = d2_rl_r;
            end
            `DHR_IDX_D1_LH: begin
                rd_val = d1_lh_r;
            end
            `DHR_IDX_D1_LL: begin
                rd_val = {d1_ll_r, 4'h0};
            end
            `DHR_IDX_D2_LH: begin
                rd_val = d2_lh_r;
            end
            `DHR_IDX_D2_LL: begin
                rd_val = {d2_ll_r, 4'h0};
            end
            `DHR_IDX_D1_B: begin
                rd_val = d1_b_r;
            end
            `DHR_IDX_D2_B: begin
                rd_val = d2_b_r;
            end
            `DHR_IDX_CH1_OH: begin
                rd_val = {4'h0, ch1_code_out[11:8]};
            end
            `DHR_IDX_CH1_OL: begin
                rd_val = ch1_code_out[7:0];
            end
            `DHR_IDX_CH2_OH: begin
                rd_val = {4'h0, ch2_code_out[11:8]};
            end
            `DHR_IDX_CH2_OL: begin
                rd_val = ch2_code_out[7:0];
            end
            `DHR_IDX_CTRL: begin
                rd_val = {6'h00, trigger_enable_r};
            end
            default: begin
                rd_val = 8'h00; // Trigger strobes and holes
            end
        endcase
    end

    // APB answer: one wait state, data and error latched with pready
    // The wait state lets the read mux settle off the address decode
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else begin
            pready_out <= acc & ~pready_out;
            pslverr_out <= acc & ~pready_out & ~mapped;
            if (acc && !pready_out) begin
                prdata_out <= {24'h00_0000, rd_val};
            end
        end
    end

    // Staging registers; high writes never touch the holding value
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            c1_rh_r <= `DHR_RST_NIB;
            c1_rl_r <= `DHR_RST_BYTE;
            c1_lh_r <= `DHR_RST_BYTE;
            c1_ll_r <= `DHR_RST_NIB;
            c1_b_r <= `DHR_RST_BYTE;
            c2_rh_r <= `DHR_RST_NIB;
            c2_rl_r <= `DHR_RST_BYTE;
            c2_lh_r <= `DHR_RST_BYTE;
            c2_ll_r <= `DHR_RST_NIB;
            c2_b_r <= `DHR_RST_BYTE;
            d1_rh_r <= `DHR_RST_NIB;
            d1_rl_r <= `DHR_RST_BYTE;
            d2_rh_r <= `DHR_RST_NIB;
            d2_rl_r <= `DHR_RST_BYTE;
            d1_lh_r <= `DHR_RST_BYTE;
            d1_ll_r <= `DHR_RST_NIB;
            d2_lh_r <= `DHR_RST_BYTE;
            d2_ll_r <= `DHR_RST_NIB;
            d1_b_r <= `DHR_RST_BYTE;
            d2_b_r <= `DHR_RST_BYTE;
            trigger_enable_r <= `DHR_RST_CTRL;
        end else if (wr) begin
            case (idx)
                `DHR_IDX_CH1_RH: c1_rh_r <= wd[3:0];
                `DHR_IDX_CH1_RL: c1_rl_r <= wd;
                `DHR_IDX_CH1_LH: c1_lh_r <= wd;
                `DHR_IDX_CH1_LL: c1_ll_r <= wd[7:4];
                `DHR_IDX_CH1_B: c1_b_r <= wd;
                `DHR_IDX_CH2_RH: c2_rh_r <= wd[3:0];
                `DHR_IDX_CH2_RL: c2_rl_r <= wd;
                `DHR_IDX_CH2_LH: c2_lh_r <= wd;
                `DHR_IDX_CH2_LL: c2_ll_r <= wd[7:4];
                `DHR_IDX_CH2_B: c2_b_r <= wd;
                `DHR_IDX_D1_RH: d1_rh_r <= wd[3:0];
                `DHR_IDX_D1_RL: d1_rl_r <= wd;
                `DHR_IDX_D2_RH: d2_rh_r <= wd[3:0];
                `DHR_IDX_D2_RL: d2_rl_r <= wd;
                `DHR_IDX_D1_LH: d1_lh_r <= wd;
                `DHR_IDX_D1_LL: d1_ll_r <= wd[7:4];
                `DHR_IDX_D2_LH: d2_lh_r <= wd;
                `DHR_IDX_D2_LL: d2_ll_r <= wd[7:4];
                `DHR_IDX_D1_B: d1_b_r <= wd;
                `DHR_IDX_D2_B: d2_b_r <= wd;
                `DHR_IDX_CTRL: trigger_enable_r <= wd[1:0];
                default: begin
                    // Output and strobe registers store nothing here
                end
            endcase
        end
    end

    // Software trigger strobes last exactly one cycle
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            swtrig_r <= 2'b00;
        end else if (wr && idx == `DHR_IDX_SWTRIG) begin
            swtrig_r <= wd[1:0];
        end else begin
            swtrig_r <= 2'b00;
        end
    end

    // Load requests from committing low-register and byte-register writes
    // Loads happen whatever the trigger enable; it only gates the output move
    always @* begin
        ld1_full = 1'b0;
        full1 = 12'h000;
        ld1_hi = 1'b0;
        hi1 = 8'h00;
        ld2_full = 1'b0;
        full2 = 12'h000;
        ld2_hi = 1'b0;
        hi2 = 8'h00;
        if (wr) begin
            case (idx)
                `DHR_IDX_CH1_RL: begin
                    ld1_full = 1'b1;
                    full1 = {c1_rh_r, wd};
                end
                `DHR_IDX_CH1_LL: begin
                    ld1_full = 1'b1;
                    full1 = {c1_lh_r, wd[7:4]};
                end
                `DHR_IDX_CH1_B: begin
                    ld1_hi = 1'b1;
                    hi1 = wd;
                end
                `DHR_IDX_CH2_RL: begin
                    ld2_full = 1'b1;
                    full2 = {c2_rh_r, wd};
                end
                `DHR_IDX_CH2_LL: begin
                    ld2_full = 1'b1;
                    full2 = {c2_lh_r, wd[7:4]};
                end
                `DHR_IDX_CH2_B: begin
                    ld2_hi = 1'b1;
                    hi2 = wd;
                end
                `DHR_IDX_D2_RL: begin
                    ld1_full = 1'b1;
                    full1 = {d1_rh_r, d1_rl_r};
                    ld2_full = 1'b1;
                    full2 = {d2_rh_r, wd};
                end
                `DHR_IDX_D2_LL: begin
                    ld1_full = 1'b1;
                    full1 = {d1_lh_r, d1_ll_r};
                    ld2_full = 1'b1;
                    full2 = {d2_lh_r, wd[7:4]};
                end
                `DHR_IDX_D2_B: begin
                    ld1_hi = 1'b1;
                    hi1 = d1_b_r;
                    ld2_hi = 1'b1;
                    hi2 = wd;
                end
                default: begin
                    // Staging and control writes load nothing
                end
            endcase
        end
    end

    // Trigger pins cross into the clock domain
    dhr_sync u_sync1 (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .pin_in(trig_ch1_in),
        .rise_out(pin1_rise)
    );

    dhr_sync u_sync2 (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .pin_in(trig_ch2_in),
        .rise_out(pin2_rise)
    );

    // Channel 1; both channels share one clock so dual moves line up
    dhr_chan #(.W(12)) u_ch1 (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .ld_full_in(ld1_full),
        .full_in(full1),
        .ld_hi_in(ld1_hi),
        .hi_in(hi1),
        .trig_en_in(trigger_enable_r[`DHR_BIT_TEN1]),
        .trig_in(pin1_rise | swtrig_r[`DHR_BIT_SW1]),
        .hold_out(hold1),
        .code_out(ch1_code_out)
    );

    // Channel 2; loads are never raised when not built, so it stays at zero
    dhr_chan #(.W(12)) u_ch2 (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .ld_full_in(ld2_full),
        .full_in(full2),
        .ld_hi_in(ld2_hi),
        .hi_in(hi2),
        .trig_en_in(trigger_enable_r[`DHR_BIT_TEN2]),
        .trig_in(pin2_rise | swtrig_r[`DHR_BIT_SW2]),
        .hold_out(hold2),
        .code_out(ch2_code_out)
    );
endmodule

// >>> rtl/dhr_sync.v
// Two-stage synchroniser with rising-edge pulse for a trigger pin.
// Assumes the pin is asynchronous to clk_sys_in.
`timescale 1ns/10ps
module dhr_sync (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire pin_in,
    output reg rise_out
);
    reg meta_r; // First stage, read only by stage two
    reg stable_r; // Second stage, safe to use
    reg prev_r; // Delayed copy for edge detection

    // Synchronise and detect a rising edge
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_r <= 1'b0;
            stable_r <= 1'b0;
            prev_r <= 1'b0;
            rise_out <= 1'b0;
        end else begin
            meta_r <= pin_in;
            stable_r <= meta_r;
            prev_r <= stable_r;
            rise_out <= stable_r & ~prev_r;
        end
    end
endmodule

// >>> tb/dhr_regs_properties.sv
// Checker for the holding register front end: APB timing, read fields, code moves.
// Assumes it is bound to dhr_regs and sees only that module's ports.
`timescale 1ns/10ps
module dhr_regs_properties (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    input wire [31:0] prdata_out,
    input wire pready_out,
    input wire pslverr_out,
    input wire [11:0] ch1_code_out,
    input wire [11:0] ch2_code_out
);
    // One clock domain, so one default clocking and reset
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);
    wire [5:0] idx = paddr_in[7:2]; // Word index of the transfer
    wire done_w = psel_in && penable_in && pready_out; // Transfer completes
    wire rd_w = done_w && !pwrite_in; // Read completes
    reg [1:0] ten_r; // Trigger enables as last written
    // Mirror the enables: a triggered channel moves its code later, so skip it
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ten_r <= 2'h0;
        end else if (done_w && pwrite_in && idx == 6'h34) begin
            ten_r <= pwdata_in[1:0];
        end
    end
    // Completed write to one index
    sequence wr_s(i);
        done_w && pwrite_in && idx == i;
    endsequence
    // Completed channel one write while untriggered
    sequence commit1_s(i);
        wr_s(i) ##0 !ten_r[0];
    endsequence
    ready_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("ready not given after one wait state");
    ready_only_a: assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside an access phase");
    resv_high_a: assert property (rd_w && idx inside {6'h08, 6'h14, 6'h20, 6'h22, 6'h2c, 6'h30}
        |-> prdata_out[31:4] == 28'h0) else $error("reserved high bits not zero");
    resv_left_a: assert property (rd_w && idx inside {6'h0d, 6'h19, 6'h25, 6'h27}
        |-> prdata_out[3:0] == 4'h0) else $error("reserved low bits not zero");
    out_high_a: assert property (rd_w && idx == 6'h2c && $stable(ch1_code_out)
        |-> prdata_out == {28'h0, ch1_code_out[11:8]}) else $error("output high read wrong");
    out_low_a: assert property (rd_w && idx == 6'h2d && $stable(ch1_code_out)
        |-> prdata_out == {24'h0, ch1_code_out[7:0]}) else $error("output low read wrong");
    right_low_a: assert property (commit1_s(6'h09)
        |-> ##2 ch1_code_out[7:0] == $past(pwdata_in[7:0], 2)) else $error("right low commit wrong");
    left_low_a: assert property (commit1_s(6'h0d)
        |-> ##2 ch1_code_out[3:0] == $past(pwdata_in[7:4], 2)) else $error("left low commit wrong");
    byte_keep_a: assert property (commit1_s(6'h10)
        |-> ##2 ch1_code_out == {$past(pwdata_in[7:0], 2), $past(ch1_code_out[3:0])})
        else $error("byte commit wrong");
    dual_byte_a: assert property (wr_s(6'h29) ##0 ten_r == 2'h0
        |-> ##2 ch2_code_out[11:4] == $past(pwdata_in[7:0], 2) && ch1_code_out[3:0] == $past(ch1_code_out[3:0]))
        else $error("dual byte commit wrong");
    err_unmap_a: assert property (done_w && idx inside {6'h0a, 6'h3f} |-> pslverr_out)
        else $error("unmapped access not refused");
endmodule
bind dhr_regs dhr_regs_properties dhr_regs_properties_inst (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .ch1_code_out(ch1_code_out),
    .ch2_code_out(ch2_code_out)
);

// >>> tb/dhr_regs_tb_top.sv
// Self-checking bench for the holding register front end, driven over APB.
// Assumes dhr_regs with channel two built and the checker bound to it.
`timescale 1ns/10ps
`include "dhr_map.vh"
module dhr_regs_tb_top;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg psel = 1'b0;
    reg pen = 1'b0;
    reg pwr = 1'b0;
    reg trig2 = 1'b0; // Channel two trigger pin
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [11:0] code1;
    wire [11:0] code2;
    integer bad_count = 0;
    integer checks = 0;
    integer i;
    reg [16:0] rnd = 17'd80471; // Stimulus generator state
    reg [33:0] notes[$]; // Expected {write, error, data} per transfer
    reg [33:0] n;
    reg [11:0] e[0:1]; // Expected code per channel
    reg [7:0] a;
    reg [7:0] b;
    reg [5:0] o;
    dhr_regs #(.HAS_CH2(1)) dhr_regs_inst (
        .clk_sys_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwdata), .trig_ch1_in(1'b0), .trig_ch2_in(trig2),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .ch1_code_out(code1), .ch2_code_out(code2)
    );
    // Free-running system clock
    initial begin
        forever #20 clk = ~clk;
    end
    function [16:0] lfsr(input [16:0] s);
        lfsr = {s[15:0], s[16] ^ s[13]};
    endfunction
    // Fresh random bytes for the next pair of writes
    task roll;
        begin
            rnd = lfsr(rnd);
            a = rnd[7:0];
            rnd = lfsr(rnd);
            b = rnd[7:0];
        end
    endtask
    // One APB transfer; keeps psel up so the next setup can follow at once
    task apb(input w, input [5:0] x, input [7:0] d, input [7:0] ed, input ee);
        begin
            notes.push_back({w, ee, 24'h0, ed});
            psel <= 1'b1;
            pen <= 1'b0;
            pwr <= w;
            paddr <= {x, 2'b00};
            pwdata <= {24'h0, d};
            @(posedge clk);
            pen <= 1'b1;
            // Wait as long as the slave needs; only the watchdog ends a hang
            do begin
                @(posedge clk);
            end while (pready !== 1'b1);
        end
    endtask
    task wr(input [5:0] x, input [7:0] d);
        apb(1'b1, x, d, 8'h00, 1'b0);
    endtask
    task rd(input [5:0] x, input [7:0] ed);
        apb(1'b0, x, 8'h00, ed, 1'b0);
    endtask
    // Release the bus, wait, then check both codes at the pins and by read
    task code(input integer c);
        begin
            psel <= 1'b0;
            pen <= 1'b0;
            repeat (c) @(posedge clk);
            checks = checks + 1;
            if ({code1, code2} !== {e[0], e[1]}) begin
                bad_count = bad_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, {code1, code2}, {e[0], e[1]});
            end
            rd(6'h2c, {4'h0, e[0][11:8]});
            rd(6'h2d, e[0][7:0]);
            rd(6'h30, {4'h0, e[1][11:8]});
            rd(6'h31, e[1][7:0]);
        end
    endtask
    // Compare each completed transfer with the oldest note
    always @(posedge clk) begin
        if (psel && pen && pready === 1'b1) begin
            n = notes.pop_front();
            checks = checks + 1;
            if (n[33] ? pslverr !== n[32] : {pslverr, prdata} !== n[32:0]) begin
                bad_count = bad_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, {pslverr, prdata}, n[32:0]);
            end
        end
    end
    task test_done;
        begin
            if (notes.size() != 0) begin
                bad_count = bad_count + 1;
            end
            $display("checks=%0d bad_count=%0d", checks, bad_count);
            if (bad_count == 0 && checks > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    // Cut a hang short well past the expected run of under a thousand cycles
    initial begin
        #(40 * 4000);
        bad_count = bad_count + 1;
        test_done;
    end
    // Main sequence
    initial begin
        e[0] = 12'h000;
        e[1] = 12'h000;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Every index: mapped ones read zero, holes are refused
        for (i = 0; i < 64; i = i + 1) begin
            apb(1'b0, i[5:0], 8'h00, 8'h00, !((64'h0033_33ff_1331_3300 >> i) & 64'h1));
        end
        apb(1'b1, 6'h3f, 8'h5a, 8'h00, 1'b1);
        for (i = 0; i < 2; i = i + 1) begin
            o = i ? 6'h0c : 6'h00;
            roll;
            wr(6'h08 + o, a);
            rd(6'h08 + o, {4'h0, a[3:0]});
            code(3);
            wr(6'h09 + o, b);
            e[i] = {a[3:0], b};
            code(3);
            wr(6'h0c + o, a);
            wr(6'h0d + o, b);
            rd(6'h0d + o, b & 8'hf0);
            e[i] = {a, b[7:4]};
            code(3);
            roll;
            wr(6'h10 + o, a);
            e[i] = {a, e[i][3:0]};
            code(3);
        end
        roll;
        wr(6'h20, a);
        wr(6'h21, b);
        wr(6'h22, b);
        code(3);
        wr(6'h23, a);
        e[0] = {a[3:0], b};
        e[1] = {b[3:0], a};
        code(3);
        wr(6'h24, a);
        wr(6'h25, b);
        wr(6'h26, b);
        wr(6'h27, a);
        rd(6'h27, a & 8'hf0);
        e[0] = {a, b[7:4]};
        e[1] = {b, a[7:4]};
        code(3);
        roll;
        wr(6'h28, a);
        wr(6'h29, b);
        e[0] = {a, e[0][3:0]};
        e[1] = {b, e[1][3:0]};
        code(3);
        wr(6'h2d, a);
        wr(6'h30, b);
        code(3);
        wr(`DHR_IDX_CTRL, 8'h03);
        wr(6'h10, b);
        wr(6'h1c, a);
        code(4);
        wr(`DHR_IDX_SWTRIG, 8'h01);
        e[0] = {b, e[0][3:0]};
        code(3);
        trig2 <= 1'b1;
        e[1] = {a, e[1][3:0]};
        code(8);
        trig2 <= 1'b0;
        wr(`DHR_IDX_CTRL, 8'h00);
        // Release the bus and let the last completion be compared first
        psel <= 1'b0;
        pen <= 1'b0;
        repeat (2) @(posedge clk);
        test_done;
    end
endmodule
